//--- dv/ampcfg_checker.sv
// Concurrent checks on the configuration bank ports
`timescale 1ns/100ps
module ampcfg_checker
  import ampcfg_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic reg_rd_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rdata_valid_out,
  input wire logic overcurrent_warning_n_in,
  input wire logic limit_reduce_active_out,
  input wire logic pwm_edge_in,
  input wire logic comp_pulse_out,
  input wire logic [1:0] output_stage_mode_out,
  input wire ampcfg_pkg::ampcfg_path_t path_cfg_out,
  input wire logic sample_valid_in,
  input wire logic [ampcfg_pkg::NUM_CH-1:0][ampcfg_pkg::SAMPLE_W-1:0] sample_in,
  input wire logic [ampcfg_pkg::NUM_CH-1:0] channel_mute_out,
  input wire logic [ampcfg_pkg::NUM_CH-1:0][ampcfg_pkg::COEF_W-1:0] postscale_in,
  input wire logic [ampcfg_pkg::NUM_CH-1:0][ampcfg_pkg::COEF_W-1:0] postscale_out,
  input wire logic [ampcfg_pkg::NUM_CH-1:0][ampcfg_pkg::CH_IDX_W-1:0] biquad_bank_sel_out
);
  logic [4:0] pulse_run;
  // Cycles of pulse since the last trigger
  always_ff @(posedge clk_sys_in)
    pulse_run <= (srst_in || pwm_edge_in) ? 5'h00 : pulse_run + {4'h0, comp_pulse_out};
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  a_spare_bit_read: assert property (reg_rd_en_in |=> reg_rdata_valid_out &&
    (!reg_rdata_out[6] || $past(reg_addr_in) != 8'h02)) else $error("read answer or spare bit wrong");
  a_oc_cause: assert property ($rose(limit_reduce_active_out) |-> !$past(overcurrent_warning_n_in))
    else $error("limit reduction without warning");
  a_oc_sticky: assert property (limit_reduce_active_out |=> limit_reduce_active_out)
    else $error("limit reduction dropped");
  a_pulse_gate: assert property ($rose(comp_pulse_out) |-> $past(pwm_edge_in) &&
    output_stage_mode_out == MODE_VARIABLE_COMP) else $error("pulse outside variable mode");
  a_pulse_length: assert property (pulse_run <= 5'h0f) else $error("pulse too long");
  a_zero_run: assert property ($rose(channel_mute_out[0]) |-> $past(sample_valid_in) &&
    $past(sample_in[0]) == 24'h000000) else $error("mute without zero sample");
  a_zero_break: assert property (sample_valid_in && sample_in[0] != 24'h000000 |=> !channel_mute_out[0])
    else $error("mute held after nonzero sample");
  a_post_link: assert property (path_cfg_out.postscale_link && $past(path_cfg_out.postscale_link)
    |-> postscale_out[1] == $past(postscale_in[0])) else $error("post-scale link wrong");
  a_bank_link: assert property (path_cfg_out.biquad_coeff_link && $past(path_cfg_out.biquad_coeff_link)
    |-> biquad_bank_sel_out[1] == 1'b0) else $error("biquad link wrong");
endmodule
bind ampcfg_regs_top ampcfg_checker ampcfg_checker_i (.*);

//--- dv/ampcfg_host_model.sv
// Host model issuing register write and read strobes
`timescale 1ns/100ps
module ampcfg_host_model
(
  input wire logic clk_sys_in,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in,
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out
);
  initial {wr_en_out, rd_en_out, addr_out, wdata_out} = 18'h0;
  // Released lines show inverted values, never the last ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    {wr_en_out, addr_out, wdata_out} <= {1'b1, a, d};
    @(posedge clk_sys_in);
    {wr_en_out, addr_out, wdata_out} <= {1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_sys_in);
    {rd_en_out, addr_out} <= {1'b1, a};
    @(posedge clk_sys_in);
    {rd_en_out, addr_out} <= {1'b0, ~a};
    // Answer taken at the edge where valid stands
    @(posedge clk_sys_in);
    d = rdata_in;
    v = rvalid_in;
  endtask
endmodule

//--- dv/ampcfg_regs_top_tb_top.sv
// Self-checking bench for the amplifier configuration bank
`timescale 1ns/100ps
module ampcfg_regs_top_tb_top;
  import ampcfg_pkg::*;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic reg_wr_en_in, reg_rd_en_in, reg_rdata_valid_out, limit_reduce_active_out, comp_pulse_out;
  logic overcurrent_warning_n_in = 1'b1, pwm_edge_in = 1'b0, sample_valid_in = 1'b0;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, rdata, limiter_threshold_out;
  logic [7:0] limiter_threshold_in = 8'h30, volume_atten_in = 8'h10;
  logic [1:0] output_stage_mode_out, channel_mute_out;
  logic [NUM_CH-1:0][CH_IDX_W-1:0] biquad_bank_sel_out;
  logic [COEF_W-1:0] warning_limit_level_in = 24'h5a5a5a, limit_level_out;
  ampcfg_path_t path_cfg_out;
  logic [NUM_CH-1:0][SAMPLE_W-1:0] sample_in = {24'h000001, 24'h000000};
  logic [NUM_CH-1:0][COEF_W-1:0] postscale_in = {24'h222222, 24'h111111}, postscale_out;
  logic [7:0] cfgs [6] = '{8'hbc, 8'hbd, 8'hbe, 8'hbf, 8'h83, 8'h87};
  int lens [6] = '{0, 0, 0, COMP_PULSE_MAX_TICKS, 0, 1};
  int err_total = 0;
  int compares = 0;
  int n;
  ampcfg_regs_top ampcfg_regs_top_i (.*);
  ampcfg_host_model ampcfg_host_model_i (.clk_sys_in(clk_sys_in), .rdata_in(reg_rdata_out),
    .rvalid_in(reg_rdata_valid_out),
    .wr_en_out(reg_wr_en_in), .rd_en_out(reg_rd_en_in), .addr_out(reg_addr_in), .wdata_out(reg_wdata_in));
  initial
  begin
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ampcfg_host_model_i.wr(a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic v;
    ampcfg_host_model_i.rd(a, rdata, v);
    chk("rvalid", 1'b1, v);
    chk("rdata", e, rdata);
  endtask
  task automatic settle;
    repeat (3) @(negedge clk_sys_in);
  endtask
  task automatic pulse_len(input logic [7:0] cfg, input int e);
    wr(8'h02, cfg);
    settle;
    chk("mode", cfg[1:0], output_stage_mode_out);
    @(posedge clk_sys_in) pwm_edge_in <= 1'b1;
    @(posedge clk_sys_in) pwm_edge_in <= 1'b0;
    n = 0;
    repeat (20) @(negedge clk_sys_in) if (comp_pulse_out !== 1'b0) n++;
    chk("pulse", e, n);
  endtask
  task automatic feed(input int cnt, input logic [SAMPLE_W-1:0] v);
    repeat (cnt)
    begin
      @(posedge clk_sys_in) {sample_valid_in, sample_in[0]} <= {1'b1, v};
      @(posedge clk_sys_in) sample_valid_in <= 1'b0;
    end
    settle;
  endtask
  initial
  begin
    #3000000;
    err_total++;
    close_out;
  end
  initial
  begin
    repeat (6) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    rdchk(8'h02, 8'h9f);
    rdchk(8'h03, 8'h40);
    wr(8'h05, 8'h12);
    rdchk(8'h05, 8'h00);
    wr(8'h02, 8'hff);
    rdchk(8'h02, 8'hbf);
    $display("test reset and access done");
    for (int i = 0; i < 6; i++)
      pulse_len(cfgs[i], lens[i]);
    $display("test output stage done");
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h03, 8'h01 << i);
      rdchk(8'h03, 8'h01 << i);
      chk("path", 8'h01 << i, path_cfg_out);
    end
    wr(8'h03, 8'h38);
    settle;
    chk("post", postscale_in[0], postscale_out[1]);
    chk("bank", 2'h0, biquad_bank_sel_out);
    chk("thr", 8'h20, limiter_threshold_out);
    @(posedge clk_sys_in) volume_atten_in <= 8'h40;
    settle;
    chk("thr", 8'h00, limiter_threshold_out);
    wr(8'h03, 8'h00);
    settle;
    chk("post", postscale_in[1], postscale_out[1]);
    chk("bank", 2'h2, biquad_bank_sel_out);
    chk("thr", 8'h30, limiter_threshold_out);
    $display("test path done");
    @(posedge clk_sys_in) overcurrent_warning_n_in <= 1'b0;
    settle;
    chk("oc", 1'b0, limit_reduce_active_out);
    @(posedge clk_sys_in) overcurrent_warning_n_in <= 1'b1;
    wr(8'h02, 8'h1f);
    @(posedge clk_sys_in) overcurrent_warning_n_in <= 1'b0;
    @(posedge clk_sys_in) overcurrent_warning_n_in <= 1'b1;
    wr(8'h02, 8'h9f);
    settle;
    chk("oc", 1'b1, limit_reduce_active_out);
    chk("level", warning_limit_level_in, limit_level_out);
    @(posedge clk_sys_in) srst_in <= 1'b1;
    @(posedge clk_sys_in) srst_in <= 1'b0;
    settle;
    chk("oc", 1'b0, limit_reduce_active_out);
    rdchk(8'h02, RST_OUTPUT_STAGE_CONFIG);
    rdchk(8'h03, RST_PROCESSING_PATH_CONFIG);
    $display("test overcurrent done");
    feed(2047, 24'h000000);
    chk("mute", 2'h0, channel_mute_out);
    feed(1, 24'h000000);
    chk("mute", 2'h1, channel_mute_out);
    feed(1, 24'h000010);
    chk("mute", 2'h0, channel_mute_out);
    feed(2047, 24'h000000);
    chk("mute", 2'h0, channel_mute_out);
    wr(8'h03, 8'h00);
    feed(2048, 24'h000000);
    chk("mute", 2'h0, channel_mute_out);
    $display("test zero detect done");
    close_out;
  end
endmodule

//--- hw/ampcfg_comp_pulse.sv
// Compensating pulse generator for the variable drop compensation mode
`timescale 1ns/100ps
module ampcfg_comp_pulse
  import ampcfg_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic [1:0] output_stage_mode_in,
  input wire logic [3:0] comp_pulse_size_in,
  input wire logic trigger_in,
  output logic pulse_out
);
  import ampcfg_pkg::*;

  typedef struct packed {
    logic [3:0] remain;
    logic active;
  } ampcfg_cp_state_t;

  ampcfg_cp_state_t st;
  ampcfg_cp_state_t next_st;

  always_comb
  begin
    next_st = st;
    if (trigger_in && output_stage_mode_in == MODE_VARIABLE_COMP && comp_pulse_size_in != 4'h0)
    begin
      next_st.remain = comp_pulse_size_in - 4'h1;
      next_st.active = 1'b1;
    end
    else if (st.active)
    begin
      if (st.remain == 4'h0)
      begin
        next_st.active = 1'b0;
      end
      else
      begin
        next_st.remain = st.remain - 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign pulse_out = st.active;
endmodule

//--- hw/ampcfg_pkg.sv
// Shared constants and types for the amplifier configuration bank
package ampcfg_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_OUTPUT_STAGE_CONFIG = 8'h02;
  localparam logic [7:0] ADDR_PROCESSING_PATH_CONFIG = 8'h03;
  localparam logic [7:0] RST_OUTPUT_STAGE_CONFIG = 8'h9f;
  localparam logic [7:0] RST_PROCESSING_PATH_CONFIG = 8'h40;
  localparam logic [7:0] OUTPUT_STAGE_WRITE_MASK = 8'hbf;

  // ----------------------------------------
  // Output stage modes
  // ----------------------------------------
  localparam logic [1:0] MODE_DROP_COMP = 2'h0;
  localparam logic [1:0] MODE_TAPERED_COMP = 2'h1;
  localparam logic [1:0] MODE_FULL_POWER = 2'h2;
  localparam logic [1:0] MODE_VARIABLE_COMP = 2'h3;

  // ----------------------------------------
  // Sizes and timing
  // ----------------------------------------
  localparam int NUM_CH = 2;
  localparam int CH_IDX_W = 1;
  localparam int SAMPLE_W = 24;
  localparam int COEF_W = 24;
  localparam int VOL_W = 8;
  localparam int COMP_TICK_NS = 20;
  localparam int COMP_PULSE_MAX_NS = 300;
  localparam int COMP_PULSE_MAX_TICKS = COMP_PULSE_MAX_NS / COMP_TICK_NS;
  localparam int ZERO_CNT_W = 12;
  localparam logic [ZERO_CNT_W-1:0] ZERO_RUN_LEN = 12'h800;

  // ----------------------------------------
  // Register layouts
  // ----------------------------------------
  typedef struct packed {
    logic overcurrent_adjust_bypass;
    logic spare;
    logic [3:0] comp_pulse_size;
    logic [1:0] output_stage_mode;
  } ampcfg_outstage_t;

  typedef struct packed {
    logic submix_enable;
    logic zero_detect_mute_enable;
    logic limiter_compress_mode;
    logic biquad_coeff_link;
    logic postscale_link;
    logic equaliser_bypass;
    logic deemphasis_enable;
    logic highpass_bypass;
  } ampcfg_path_t;

endpackage

//--- hw/ampcfg_regs_top.sv
// Output stage and processing path configuration bank of the amplifier controller
`timescale 1ns/100ps
module ampcfg_regs_top
  import ampcfg_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic reg_wr_en_in,
  input wire logic reg_rd_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rdata_valid_out,
  input wire logic overcurrent_warning_n_in,
  input wire logic [ampcfg_pkg::COEF_W-1:0] warning_limit_level_in,
  output logic limit_reduce_active_out,
  output logic [ampcfg_pkg::COEF_W-1:0] limit_level_out,
  input wire logic pwm_edge_in,
  output logic comp_pulse_out,
  output logic [1:0] output_stage_mode_out,
  output ampcfg_pkg::ampcfg_path_t path_cfg_out,
  input wire logic sample_valid_in,
  input wire logic [ampcfg_pkg::NUM_CH-1:0][ampcfg_pkg::SAMPLE_W-1:0] sample_in,
  output logic [ampcfg_pkg::NUM_CH-1:0] channel_mute_out,
  input wire logic [ampcfg_pkg::NUM_CH-1:0][ampcfg_pkg::COEF_W-1:0] postscale_in,
  output logic [ampcfg_pkg::NUM_CH-1:0][ampcfg_pkg::COEF_W-1:0] postscale_out,
  output logic [ampcfg_pkg::NUM_CH-1:0][ampcfg_pkg::CH_IDX_W-1:0] biquad_bank_sel_out,
  input wire logic [ampcfg_pkg::VOL_W-1:0] limiter_threshold_in,
  input wire logic [ampcfg_pkg::VOL_W-1:0] volume_atten_in,
  output logic [ampcfg_pkg::VOL_W-1:0] limiter_threshold_out
);
  import ampcfg_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    ampcfg_outstage_t out_cfg;
    ampcfg_path_t path;
    logic limit_hold;
    logic [COEF_W-1:0] limit_level;
    logic [7:0] rdata;
    logic rvalid;
    logic [1:0] mode;
    logic [NUM_CH-1:0][COEF_W-1:0] postscale;
    logic [NUM_CH-1:0][CH_IDX_W-1:0] bank;
    logic [VOL_W-1:0] threshold;
  } ampcfg_top_state_t;

  ampcfg_top_state_t st;
  ampcfg_top_state_t next_st;
  logic [NUM_CH-1:0] zd_mute;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [CH_IDX_W-1:0] src_channel(input logic link, input int ch);
    logic [CH_IDX_W-1:0] idx;
    idx = CH_IDX_W'(ch);
    if (link)
    begin
      idx = '0;
    end
    return idx;
  endfunction

  function automatic logic [VOL_W-1:0] sat_sub(input logic [VOL_W-1:0] a, input logic [VOL_W-1:0] b);
    logic [VOL_W-1:0] r;
    r = '0;
    if (a > b)
    begin
      r = a - b;
    end
    return r;
  endfunction

  function automatic logic hits_outstage(input logic [7:0] addr);
    return addr == ADDR_OUTPUT_STAGE_CONFIG;
  endfunction

  function automatic logic hits_path(input logic [7:0] addr);
    return addr == ADDR_PROCESSING_PATH_CONFIG;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.rvalid = 1'b0;

    // Register writes
    if (reg_wr_en_in)
    begin
      if (hits_outstage(reg_addr_in))
      begin
        next_st.out_cfg = ampcfg_outstage_t'(reg_wdata_in & OUTPUT_STAGE_WRITE_MASK);
      end
      else if (hits_path(reg_addr_in))
      begin
        next_st.path = ampcfg_path_t'(reg_wdata_in);
      end
    end

    // Register reads
    if (reg_rd_en_in)
    begin
      next_st.rvalid = 1'b1;
      if (hits_outstage(reg_addr_in))
      begin
        next_st.rdata = 8'(st.out_cfg) & OUTPUT_STAGE_WRITE_MASK;
      end
      else if (hits_path(reg_addr_in))
      begin
        next_st.rdata = 8'(st.path);
      end
      else
      begin
        next_st.rdata = 8'h00;
      end
    end

    next_st.mode = st.out_cfg.output_stage_mode;

    if (!st.out_cfg.overcurrent_adjust_bypass && !overcurrent_warning_n_in)
    begin
      next_st.limit_hold = 1'b1;
    end

    if (next_st.limit_hold)
    begin
      next_st.limit_level = warning_limit_level_in;
    end
    else
    begin
      next_st.limit_level = '0;
    end

    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      next_st.postscale[ch] = postscale_in[src_channel(st.path.postscale_link, ch)];
      next_st.bank[ch] = src_channel(st.path.biquad_coeff_link, ch);
    end

    if (st.path.limiter_compress_mode)
    begin
      next_st.threshold = sat_sub(limiter_threshold_in, volume_atten_in);
    end
    else
    begin
      next_st.threshold = limiter_threshold_in;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      st <= '0;
      st.out_cfg <= ampcfg_outstage_t'(RST_OUTPUT_STAGE_CONFIG);
      st.path <= ampcfg_path_t'(RST_PROCESSING_PATH_CONFIG);
      st.mode <= RST_OUTPUT_STAGE_CONFIG[1:0];
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Compensating pulse
  // ----------------------------------------
  ampcfg_comp_pulse u_comp_pulse (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .output_stage_mode_in(st.out_cfg.output_stage_mode),
    .comp_pulse_size_in(st.out_cfg.comp_pulse_size),
    .trigger_in(pwm_edge_in),
    .pulse_out(comp_pulse_out)
  );

  // ----------------------------------------
  // Zero-detect mute
  // ----------------------------------------
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_zd
    ampcfg_zero_det u_zero_det (
      .clk_sys_in(clk_sys_in),
      .srst_in(srst_in),
      .enable_in(st.path.zero_detect_mute_enable),
      .sample_valid_in(sample_valid_in),
      .sample_in(sample_in[g]),
      .mute_out(zd_mute[g])
    );
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata_out = st.rdata;
  assign reg_rdata_valid_out = st.rvalid;
  assign limit_reduce_active_out = st.limit_hold;
  assign limit_level_out = st.limit_level;
  assign output_stage_mode_out = st.mode;
  assign path_cfg_out = st.path;
  assign channel_mute_out = zd_mute;
  assign postscale_out = st.postscale;
  assign biquad_bank_sel_out = st.bank;
  assign limiter_threshold_out = st.threshold;
endmodule

//--- hw/ampcfg_zero_det.sv
// Per-channel zero run detector driving the automatic mute
`timescale 1ns/100ps
module ampcfg_zero_det
  import ampcfg_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic enable_in,
  input wire logic sample_valid_in,
  input wire logic [SAMPLE_W-1:0] sample_in,
  output logic mute_out
);
  import ampcfg_pkg::*;

  typedef struct packed {
    logic [ZERO_CNT_W-1:0] count;
    logic mute;
  } ampcfg_zd_state_t;

  ampcfg_zd_state_t st;
  ampcfg_zd_state_t next_st;

  always_comb
  begin
    next_st = st;
    if (!enable_in)
    begin
      next_st = '0;
    end
    else if (sample_valid_in)
    begin
      if (sample_in == '0)
      begin
        if (st.count != ZERO_RUN_LEN)
        begin
          next_st.count = st.count + 12'h001;
        end
        if (st.count + 12'h001 >= ZERO_RUN_LEN)
        begin
          next_st.mute = 1'b1;
        end
      end
      else
      begin
        next_st.count = '0;
        next_st.mute = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign mute_out = st.mute;
endmodule
